// ===== hw/srq_status_pkg.sv
// Package with constants, types and reset values for the service request and status unit.
package srq_status_pkg;

  // Status byte bit positions.
  localparam int BIT_READING_DONE = 0;
  localparam int BIT_HALF_FULL    = 1;
  localparam int BIT_FULL         = 2;
  localparam int BIT_OVERFLOW     = 3;
  localparam int BIT_CMD_READY    = 4;
  localparam int BIT_ERROR        = 5;
  localparam int BIT_RQS          = 6;
  localparam int BIT_TRIG_READY   = 7;

  // Mask weights of the selectable conditions.
  localparam logic [7:0] WEIGHT_READING_DONE = 8'h01;
  localparam logic [7:0] WEIGHT_HALF_FULL    = 8'h02;
  localparam logic [7:0] WEIGHT_FULL         = 8'h04;
  localparam logic [7:0] WEIGHT_OVERFLOW     = 8'h08;
  localparam logic [7:0] WEIGHT_CMD_READY    = 8'h10;
  localparam logic [7:0] WEIGHT_ERROR        = 8'h20;
  localparam logic [7:0] WEIGHT_TRIG_READY   = 8'h80;

  // Mask bits that exist; position 6 has no mask counterpart.
  localparam logic [7:0] MASK_VALID = 8'hBF;

  // Values after reset.
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Factory defaults of the filter settings.
  localparam logic FILTER_MASTER_FACTORY = 1'h1;
  localparam logic ANALOG_CFG_FACTORY    = 1'h0;

  // Filter settings travel together.
  typedef struct packed {
    logic master;
    logic analog;
  } filter_cfg_s;

  localparam filter_cfg_s FILTER_FACTORY = '{master: FILTER_MASTER_FACTORY, analog: ANALOG_CFG_FACTORY};

endpackage : srq_status_pkg

// ===== hw/service_request_status_unit.sv
// Service request mask, serial poll status byte and filter enable settings.
//
// Overview of operation
// - An eight-bit mask selects which status conditions may request service.
// - Status bits follow their events regardless of the mask.
// - Only conditions arising while masked in raise a request; late masking does not.
// - Status bits map onto equal mask positions, except bit 6 which has none.
// - Bits 7, 4, 3 track trigger ready, command ready and overflow.
// - Bit 0 sets on reading done; clears on result read or one-shot switch.
// - Bits 1 and 2 flag half full and full; buffer reinit clears both.
// - Thresholds come from the programmed buffer length.
// - Error bit 5 latches until the error status word is read.
// - Bit 6 and request line set on request, cleared by serial poll.
// - Overflow bit never sets while automatic ranging is active.
// - A mask may combine several condition weights at once.
// - The front panel indicator follows the service request.
// - The status byte is readable even with every request masked.
// - Master filter setting: 0 disables, 1 enables, default enabled.
// - Master enable passes each filter only where its own setting selects it.
// - Analog filter setting: 0 off, 1 on, default off, gated by master.
// - Power-up restores factory filter values; device clear or setup recall restore stored defaults.
// - Mask weights: 1,2,4,8,16,32,128 for the seven conditions.
// - Power-up, device clear or recall return the mask to all disabled.
// - Power-up and device clear clear status, indicator and request line.
`timescale 1ns/100ps

module service_request_status_unit
  import srq_status_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // Clock and reset.
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  // Measurement events.
  input  wire logic               i_trigger_ready,
  input  wire logic               i_triggered,
  input  wire logic               i_command_ready,
  input  wire logic               i_command_start,
  input  wire logic               i_overflow,
  input  wire logic               i_autorange_active,
  input  wire logic               i_reading_done,
  input  wire logic               i_converter_read,
  input  wire logic               i_trigger_one_shot,
  input  wire logic               i_error,
  input  wire logic               i_error_word_read,
  // Reading buffer.
  input  wire logic [COUNT_W-1:0] i_buffer_count,
  input  wire logic [COUNT_W-1:0] i_buffer_length,
  input  wire logic               i_buffer_reinit,
  // Bus and setup commands.
  input  wire logic               i_serial_poll,
  input  wire logic               i_device_clear,
  input  wire logic               i_recall_user_setup,
  input  wire logic               i_save_user_setup,
  input  wire logic               i_mask_write,
  input  wire logic [7:0]         i_mask_data,
  input  wire logic               i_filter_write,
  input  wire logic               i_filter_data,
  input  wire logic               i_analog_cfg_write,
  input  wire logic               i_analog_cfg_data,
  input  wire logic               i_digital_cfg_active,
  // Status and request outputs.
  output logic [7:0]              o_serial_poll_status,
  output logic                    o_srq,
  output logic                    o_srq_indicator,
  output logic [7:0]              o_mask,
  // Filter outputs.
  output logic                    o_filter_master,
  output logic                    o_analog_cfg,
  output logic                    o_analog_filter_on,
  output logic                    o_digital_filter_on
);

  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [7:0]  set_vec;
  logic [7:0]  clr_vec;
  logic [7:0]  new_events;
  logic [7:0]  mask_reg;
  logic        srq_reg;
  logic        srq_raise;
  logic        indicator_reg;
  logic        one_shot_prev_reg;
  logic        mode_to_one_shot;
  logic        half_full;
  logic        full;
  logic        analog_on_reg;
  logic        digital_on_reg;
  filter_cfg_s cfg_reg;
  filter_cfg_s stored_cfg_reg;

  // Buffer thresholds scale with the programmed length.
  assign half_full = (i_buffer_length != '0) &&
                     ({i_buffer_count, 1'b0} >= {1'b0, i_buffer_length});
  assign full      = (i_buffer_length != '0) && (i_buffer_count >= i_buffer_length);

  // Switching the trigger mode from multiple to one-shot is the rising edge of the mode level.
  assign mode_to_one_shot = i_trigger_one_shot & ~one_shot_prev_reg;

  // Set and clear terms of each status bit; bit 6 is handled with the request line.
  always_comb begin
    set_vec                   = 8'h00;
    clr_vec                   = 8'h00;
    set_vec[BIT_TRIG_READY]   = i_trigger_ready;
    clr_vec[BIT_TRIG_READY]   = i_triggered;
    set_vec[BIT_CMD_READY]    = i_command_ready;
    clr_vec[BIT_CMD_READY]    = i_command_start;
    set_vec[BIT_OVERFLOW]     = i_overflow & ~i_autorange_active;
    clr_vec[BIT_OVERFLOW]     = ~i_overflow;
    set_vec[BIT_READING_DONE] = i_reading_done;
    clr_vec[BIT_READING_DONE] = i_converter_read | mode_to_one_shot;
    set_vec[BIT_HALF_FULL]    = half_full;
    clr_vec[BIT_HALF_FULL]    = i_buffer_reinit;
    set_vec[BIT_FULL]         = full;
    clr_vec[BIT_FULL]         = i_buffer_reinit;
    set_vec[BIT_ERROR]        = i_error;
    clr_vec[BIT_ERROR]        = i_error_word_read;
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  assign status_next = (set_vec | (status_reg & ~clr_vec)) & MASK_VALID;

  // Only a condition going from clear to set counts as newly occurring.
  assign new_events = set_vec & ~status_reg & MASK_VALID;

  // The mask is sampled at the moment the condition first occurs.
  assign srq_raise = |(new_events & mask_reg);

  // Status bits update on every event whatever the mask holds.
  always_ff @(posedge i_clock) begin
    if (i_rst || i_device_clear) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Request line and its status bit; a new request beats a poll in the same cycle.
  always_ff @(posedge i_clock) begin
    if (i_rst || i_device_clear) begin
      srq_reg <= 1'b0;
    end else if (srq_raise) begin
      srq_reg <= 1'b1;
    end else if (i_serial_poll) begin
      srq_reg <= 1'b0;
    end
  end

  // Front panel indicator shadows the request line.
  always_ff @(posedge i_clock) begin
    if (i_rst || i_device_clear) begin
      indicator_reg <= 1'b0;
    end else if (srq_raise) begin
      indicator_reg <= 1'b1;
    end else if (i_serial_poll) begin
      indicator_reg <= 1'b0;
    end
  end

  // Request mask; weights combine freely and position 6 never stores.
  always_ff @(posedge i_clock) begin
    if (i_rst || i_device_clear || i_recall_user_setup) begin
      mask_reg <= MASK_RESET;
    end else if (i_mask_write) begin
      mask_reg <= i_mask_data & MASK_VALID;
    end
  end

  // Previous trigger mode level for edge detection.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      one_shot_prev_reg <= 1'b0;
    end else begin
      one_shot_prev_reg <= i_trigger_one_shot;
    end
  end

  // Stored power-on defaults of the filters; a power-up brings back the factory values.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stored_cfg_reg <= FILTER_FACTORY;
    end else if (i_save_user_setup) begin
      stored_cfg_reg <= cfg_reg;
    end
  end

  // Live filter settings with restore on clear or recall.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_reg <= FILTER_FACTORY;
    end else if (i_device_clear || i_recall_user_setup) begin
      cfg_reg <= stored_cfg_reg;
    end else begin
      if (i_filter_write) begin
        cfg_reg.master <= i_filter_data;
      end
      if (i_analog_cfg_write) begin
        cfg_reg.analog <= i_analog_cfg_data;
      end
    end
  end

  // Each filter runs only when the master enable and its own setting agree.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      analog_on_reg  <= 1'b0;
      digital_on_reg <= 1'b0;
    end else begin
      analog_on_reg  <= cfg_reg.master & cfg_reg.analog;
      digital_on_reg <= cfg_reg.master & i_digital_cfg_active;
    end
  end

  // Outputs straight from flip-flops; the byte is always readable.
  assign o_serial_poll_status = {status_reg[7], srq_reg, status_reg[5:0]};
  assign o_srq                = srq_reg;
  assign o_srq_indicator      = indicator_reg;
  assign o_mask               = mask_reg;
  assign o_filter_master      = cfg_reg.master;
  assign o_analog_cfg         = cfg_reg.analog;
  assign o_analog_filter_on   = analog_on_reg;
  assign o_digital_filter_on  = digital_on_reg;

  // Checks of the documented behaviour.
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic calm;
  assign calm = ~i_device_clear;

  a_clear_all_status: assert property (
    i_device_clear |=> (status_reg == 8'h00) && !o_srq && !o_srq_indicator)
    else $error("Device clear left status or request set.");

  a_mask_to_zero: assert property (
    i_recall_user_setup |=> (o_mask == 8'h00))
    else $error("Recall did not disable all requests.");

  a_mask_bit6_zero: assert property (
    o_mask[BIT_RQS] == 1'b0)
    else $error("Mask position 6 holds a value.");

  a_new_event_srq: assert property (
    calm && srq_raise |=> o_srq && o_serial_poll_status[BIT_RQS])
    else $error("Masked new event raised no request.");

  a_no_late_srq: assert property (
    !o_srq && !srq_raise |=> !o_srq)
    else $error("Request rose without a new masked event.");

  a_poll_clears_rqs: assert property (
    i_serial_poll && !srq_raise |=> !o_srq ##1 !o_srq_indicator || o_srq)
    else $error("Serial poll did not clear the request.");

  a_ovf_in_range: assert property (
    i_autorange_active && !status_reg[BIT_OVERFLOW] |=> !status_reg[BIT_OVERFLOW])
    else $error("Overflow set during automatic ranging.");

  a_error_latch_hold: assert property (
    calm && status_reg[BIT_ERROR] && !i_error_word_read |=> status_reg[BIT_ERROR])
    else $error("Error bit dropped before the word was read.");

  a_done_clear_read: assert property (
    calm && i_converter_read && !i_reading_done |=> !status_reg[BIT_READING_DONE])
    else $error("Result read left reading done set.");

  a_full_sets_bit: assert property (
    calm && full |=> status_reg[BIT_FULL])
    else $error("Full buffer did not set bit 2.");

  a_indicator_follow: assert property (
    o_srq_indicator == o_srq)
    else $error("Indicator differs from request line.");

  a_analog_gating: assert property (
    ##1 o_analog_filter_on == $past(cfg_reg.master && cfg_reg.analog))
    else $error("Analog filter output not gated by master.");

  a_ovf_clear_follow: assert property (
    calm && !i_overflow |=> !status_reg[BIT_OVERFLOW])
    else $error("Overflow bit stayed set after the overflow went away.");

  a_trig_ready_set: assert property (
    calm && i_trigger_ready |=> status_reg[BIT_TRIG_READY])
    else $error("Ready for trigger did not set bit 7.");

  a_cmd_busy_clear: assert property (
    calm && i_command_start && !i_command_ready |=> !status_reg[BIT_CMD_READY])
    else $error("Command start left bit 4 set.");

  a_mask_write_load: assert property (
    i_mask_write && calm && !i_recall_user_setup |=> o_mask == $past(i_mask_data & MASK_VALID))
    else $error("Mask write did not load the combined weights.");

  a_filter_restore: assert property (
    i_recall_user_setup |=> o_filter_master == $past(stored_cfg_reg.master))
    else $error("Recall did not restore the stored filter enable.");

  a_digital_gating: assert property (
    o_digital_filter_on |-> $past(o_filter_master))
    else $error("Digital filter on while filters were disabled.");

  c_request_raised: cover property (!o_srq ##1 o_srq);
  c_poll_clears: cover property (o_srq ##1 i_serial_poll ##1 !o_srq);
  c_late_mask: cover property (status_reg[BIT_ERROR] && i_mask_write && i_mask_data[BIT_ERROR]);
  c_recall_filters: cover property (i_recall_user_setup ##1 o_filter_master);

endmodule : service_request_status_unit

// ===== verification/srq_poll_controller.sv
// Bus controller model that serial polls the unit after each service request.
`timescale 1ns/100ps

module srq_poll_controller (
  input  wire logic       i_clock,
  input  wire logic       i_enable,
  input  wire logic       i_srq,
  input  wire logic [7:0] i_status,
  input  wire logic [3:0] i_delay,
  output logic            o_poll,
  output logic [7:0]      o_polled,
  output int              o_polls
);
  // Waits out a chosen delay after a request, then reads the status byte once.
  // The poll always changes one time unit after a rising edge, like the rest of the stimulus.
  initial begin
    int wait_cycles;
    o_poll = 1'b0;
    o_polled = 8'h00;
    o_polls = 0;
    forever begin
      @(posedge i_clock);
      #1;
      if (i_enable && i_srq === 1'b1) begin
        wait_cycles = i_delay;
        if (wait_cycles > 0) begin
          repeat (wait_cycles) @(posedge i_clock);
          #1;
        end
        o_poll = 1'b1;
        o_polled = i_status;
        @(posedge i_clock);
        #1 o_poll = 1'b0;
        o_polls++;
      end
    end
  end
endmodule : srq_poll_controller

// ===== verification/service_request_status_unit_tb.sv
// Self-checking testbench for the service request and status unit.
`timescale 1ns/100ps

module service_request_status_unit_tb;
  import srq_status_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rst = 1'b1;
  logic [14:0] pl = '0;
  logic       ovf = 0, aut = 0, osh = 0, dig = 0, fd = 0, ad = 0, pen = 0, poll;
  logic [7:0] cnt = '0, len = '0, md = '0, st, msk, polled, e_st, e_msk;
  logic [3:0] dly = '0;
  logic       srq, ind, fm, ac, aon, don, e_srq, e_fm, e_ac, e_aon, e_don, e_os, s_fm, s_ac;
  int         polls, fail_count = 0, check_count = 0;

  always #5 i_clock = ~i_clock;

  service_request_status_unit #(.COUNT_W(8)) service_request_status_unit_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_trigger_ready(pl[0]), .i_triggered(pl[1]),
    .i_command_ready(pl[2]), .i_command_start(pl[3]), .i_overflow(ovf), .i_autorange_active(aut),
    .i_reading_done(pl[4]), .i_converter_read(pl[5]), .i_trigger_one_shot(osh), .i_error(pl[6]),
    .i_error_word_read(pl[7]), .i_buffer_count(cnt), .i_buffer_length(len), .i_buffer_reinit(pl[8]),
    .i_serial_poll(poll), .i_device_clear(pl[9]), .i_recall_user_setup(pl[10]),
    .i_save_user_setup(pl[11]), .i_mask_write(pl[12]), .i_mask_data(md), .i_filter_write(pl[13]),
    .i_filter_data(fd), .i_analog_cfg_write(pl[14]), .i_analog_cfg_data(ad),
    .i_digital_cfg_active(dig), .o_serial_poll_status(st), .o_srq(srq), .o_srq_indicator(ind),
    .o_mask(msk), .o_filter_master(fm), .o_analog_cfg(ac), .o_analog_filter_on(aon),
    .o_digital_filter_on(don));

  srq_poll_controller srq_poll_controller_i (.i_clock(i_clock), .i_enable(pen), .i_srq(srq), .i_status(st),
    .i_delay(dly), .o_poll(poll), .o_polled(polled), .o_polls(polls));

  // Next status bits from the current bits and the inputs of this cycle.
  function automatic logic [7:0] next_bits(input logic [7:0] s);
    logic [7:0] n;
    n = s;
    if (pl[1]) n[7] = 1'b0;
    if (pl[0]) n[7] = 1'b1;
    if (pl[3]) n[4] = 1'b0;
    if (pl[2]) n[4] = 1'b1;
    n[3] = ovf & (s[3] | ~aut);
    if (pl[5] || (osh && !e_os)) n[0] = 1'b0;
    if (pl[4]) n[0] = 1'b1;
    if (pl[7]) n[5] = 1'b0;
    if (pl[6]) n[5] = 1'b1;
    if (pl[8]) n[2:1] = 2'b00;
    if (len != 0 && {1'b0, cnt, 1'b0} >= {2'b00, len}) n[1] = 1'b1;
    if (len != 0 && cnt >= len) n[2] = 1'b1;
    return n;
  endfunction : next_bits

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Advances the model one cycle per clock and compares every output.
  task automatic tick(input int n);
    logic [7:0] nb;
    repeat (n) begin
      @(negedge i_clock);
      nb = next_bits(e_st);
      if (i_rst) begin
        {e_st, e_msk, e_srq, e_aon, e_don, e_os} = '0;
        {e_fm, e_ac, s_fm, s_ac} = 4'b1010;
      end else begin
        e_aon = e_fm & e_ac;
        e_don = e_fm & dig;
        e_os = osh;
        if (pl[9]) begin
          {e_st, e_msk, e_srq} = '0;
          {e_fm, e_ac} = {s_fm, s_ac};
        end else begin
          e_srq = (|(nb & ~e_st & e_msk & MASK_VALID)) | (e_srq & ~poll);
          e_st = nb;
          if (pl[11]) {s_fm, s_ac} = {e_fm, e_ac};
          if (pl[10]) {e_msk, e_fm, e_ac} = {8'h00, s_fm, s_ac};
          if (!pl[10] && pl[12]) e_msk = md & MASK_VALID;
          if (!pl[10] && pl[13]) e_fm = fd;
          if (!pl[10] && pl[14]) e_ac = ad;
        end
      end
      @(posedge i_clock);
      #1;
      pl = '0;
      chk(st, {e_st[7], e_srq, e_st[5:0]});
      chk({6'h00, srq, ind}, {6'h00, e_srq, e_srq});
      chk(msk, e_msk);
      chk({4'h0, fm, ac, aon, don}, {4'h0, e_fm, e_ac, e_aon, e_don});
    end
  endtask : tick

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Main sequence: reset, corner cases, then random traffic.
  initial begin
    void'($urandom(32'h8ef1));
    tick(12);
    i_rst = 1'b0;
    ovf = 1;
    tick(2);
    md = 8'hFF;
    pl[12] = 1;
    tick(3);
    chk({7'h00, srq}, 8'h00);
    ovf = 0;
    tick(1);
    ovf = 1;
    tick(1);
    chk({7'h00, srq}, 8'h01);
    {aut, ovf} = 2'b10;
    tick(1);
    ovf = 1;
    tick(2);
    chk({7'h00, st[3]}, 8'h00);
    {len, cnt} = {8'd100, 8'd49};
    tick(1);
    cnt = 50;
    tick(1);
    cnt = 100;
    tick(1);
    chk({6'h00, st[2:1]}, 8'h03);
    {cnt, pl[8], pl[4], pen} = {8'd0, 3'b111};
    tick(1);
    osh = 1;
    tick(8);
    chk({6'h00, polls > 0, polled[6]}, 8'h03);
    {fd, ad, pl[14:13]} = 4'b0111;
    tick(2);
    {fd, pl[13], dig} = 3'b111;
    tick(2);
    pl[11] = 1;
    tick(1);
    {fd, pl[13]} = 2'b01;
    tick(1);
    pl[10] = 1;
    tick(2);
    {fd, pl[13]} = 2'b01;
    tick(1);
    {osh, pl[9]} = 2'b01;
    tick(2);
    // A second power-up must forget the saved filter setup before the next clear.
    i_rst = 1'b1;
    tick(2);
    {i_rst, pl[9]} = 2'b01;
    tick(2);
    for (int k = 0; k < 3000; k++) begin
      pl = 15'($urandom) & 15'($urandom) & 15'h71FF;
      pl[10] = $urandom_range(0, 63) == 0;
      pl[9] = $urandom_range(0, 99) == 0;
      if (pl[9]) osh = 0;
      else osh = $urandom_range(0, 15) == 0;
      {md, fd, ad, aut, dig, pen} = 13'($urandom);
      ovf = $urandom_range(0, 3) != 0;
      cnt = 8'($urandom_range(0, 24));
      len = 8'($urandom_range(0, 20));
      dly = 4'($urandom_range(0, 3));
      tick(1);
    end
    finish_test();
  end

  // Cuts a hang short.
  initial begin
    #60000;
    fail_count++;
    finish_test();
  end
endmodule : service_request_status_unit_tb
